// file: core/net_status_pkg.sv
// Shared constants, codes and carrier types of the network status register bank.
package net_status_pkg;

  // Register word width and the size of the relay node chain.
  localparam int REG_W = 16;
  localparam int MAX_NODES = 32;
  localparam int CNT_W = 6;

  // Holding register offsets.
  localparam logic [15:0] OFF_AUTOADDR = 16'h0001;
  localparam logic [15:0] OFF_SUBNET_MASK_LOW = 16'h0049;
  localparam logic [15:0] OFF_GATEWAY_HIGH = 16'h004a;
  localparam logic [15:0] OFF_GATEWAY_LOW = 16'h004b;
  localparam logic [15:0] OFF_ADDRESS_ASSIGN_METHOD = 16'h004c;

  // Input register offsets.
  localparam logic [15:0] OFF_CONTROLLER_ERROR_FLAGS = 16'h0100;
  localparam logic [15:0] OFF_LAST_OPERATION_CODE = 16'h0101;
  localparam logic [15:0] OFF_NODES_PRESENT_COUNT = 16'h0102;
  localparam logic [15:0] OFF_NODES_CORRECT_COUNT = 16'h0103;
  localparam logic [15:0] OFF_NODES_MISPLACED_COUNT = 16'h0104;
  localparam logic [15:0] OFF_NODES_UNADDRESSED_COUNT = 16'h0105;

  // Reset values of the network and method holding registers and the last operation register.
  localparam logic [15:0] RST_NET_WORD = 16'h0000;
  localparam logic [15:0] RST_METHOD = 16'h0000;
  localparam logic [15:0] RST_OPCODE = 16'h0000;

  // Bit positions of the controller error flag word.
  localparam int BIT_RESET = 0;
  localparam int BIT_INTERNAL = 2;
  localparam int BIT_BUS = 4;
  localparam int BIT_LIMIT = 5;
  localparam int BIT_CONFLICT = 6;
  localparam int BIT_TERMINATION = 7;
  localparam int BIT_POSITION = 8;
  localparam int BIT_SUPPLY = 9;
  localparam int BIT_UNCONFIGURED = 10;
  localparam int BIT_INCOMPATIBLE = 11;

  // Address assignment method codes.
  localparam logic [15:0] METHOD_FIXED = 16'h0000;
  localparam logic [15:0] METHOD_DHCP = 16'h0001;
  localparam logic [15:0] METHOD_BOOTP = 16'h0002;
  localparam logic [15:0] METHOD_FALLBACK = 16'h0003;

  // Auto-addressing command value and its idle value.
  localparam logic [15:0] AUTOADDR_CMD = 16'h0003;
  localparam logic [15:0] AUTOADDR_IDLE = 16'h0000;

  // Operation codes reported in the last operation register.
  localparam logic [15:0] OP_ROLL_CALL = 16'h0001;
  localparam logic [15:0] OP_AUTOADDR = 16'h0003;
  localparam logic [15:0] OP_CHECK_START = 16'h0100;
  localparam logic [15:0] OP_CHECK_STOP = 16'h0200;
  localparam logic [15:0] OP_BLOCKED = 16'hff00;

  // Protocol exception codes returned on a refused access.
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // Kind of register access asked for by the protocol engine.
  typedef enum logic [1:0] {
    ACC_READ_HOLDING,
    ACC_READ_INPUT,
    ACC_WRITE_HOLDING,
    ACC_NONE
  } access_kind_t;

  // One register access request, one register at a time.
  typedef struct packed {
    logic valid;
    access_kind_t kind;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Answer to one register access.
  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
    logic [7:0] exception;
  } reg_resp_t;

  // Error conditions reported by the controller's own logic, as levels.
  typedef struct packed {
    logic internal_err;
    logic bus_err;
    logic limit_err;
    logic conflict_err;
    logic termination_err;
    logic position_err;
    logic supply_err;
    logic unconfigured_err;
    logic incompatible_err;
  } ctrl_errors_t;

  // Address source chosen by the assignment sequencer.
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_DHCP,
    SRC_BOOTP,
    SRC_FIXED
  } addr_source_t;

  // Number of set bits in a node vector.
  function automatic logic [CNT_W-1:0] count_ones(input logic [MAX_NODES-1:0] v);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < MAX_NODES; i++) begin
      n = n + CNT_W'(v[i]);
    end
    return n;
  endfunction

endpackage

// file: core/node_tally.sv
// Counts present, correctly placed, misplaced and unaddressed relay nodes.
`timescale 1ns/1ns
module node_tally
  import net_status_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [MAX_NODES-1:0] node_present,
  input wire logic [MAX_NODES-1:0] node_addressed,
  input wire logic [MAX_NODES-1:0] node_addr_match,
  output logic [CNT_W-1:0] present_count,
  output logic [CNT_W-1:0] correct_count,
  output logic [CNT_W-1:0] misplaced_count,
  output logic [CNT_W-1:0] unaddressed_count
);

  // Next values of the four tallies.
  logic [CNT_W-1:0] next_present_count;
  logic [CNT_W-1:0] next_correct_count;
  logic [CNT_W-1:0] next_misplaced_count;
  logic [CNT_W-1:0] next_unaddressed_count;

  // Only nodes that answer the roll call are counted, so stale bits of an
  // absent position cannot inflate any tally.
  always_comb begin
    next_present_count = count_ones(node_present);
    next_correct_count = count_ones(node_present & node_addressed & node_addr_match);
    next_misplaced_count = count_ones(node_present & node_addressed & ~node_addr_match);
    next_unaddressed_count = count_ones(node_present & ~node_addressed);
  end

  // Tallies are registered so the register bank reads stable values.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      present_count <= '0;
      correct_count <= '0;
      misplaced_count <= '0;
      unaddressed_count <= '0;
    end else if (ce) begin
      present_count <= next_present_count;
      correct_count <= next_correct_count;
      misplaced_count <= next_misplaced_count;
      unaddressed_count <= next_unaddressed_count;
    end
  end

endmodule

// file: core/addr_assign_seq.sv
// Sequences the address assignment method, including the fallback chain.
`timescale 1ns/1ns
module addr_assign_seq
  import net_status_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [15:0] method,
  input wire logic start,
  input wire logic fixed_custom_set,
  input wire logic dhcp_ok,
  input wire logic dhcp_fail,
  input wire logic bootp_ok,
  input wire logic bootp_fail,
  output logic dhcp_run,
  output logic bootp_run,
  output addr_source_t source,
  output logic use_factory_fixed
);

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DHCP,
    ST_BOOTP,
    ST_DONE
  } seq_state_t;

  seq_state_t state;
  seq_state_t next_state;
  addr_source_t next_source;
  logic next_dhcp_run;
  logic next_bootp_run;
  logic next_use_factory_fixed;

  // A start picks the first step from the method held at that moment; a later
  // method write still steers the fallback after a DHCP or BOOTP failure.
  always_comb begin
    next_state = state;
    next_source = source;
    next_use_factory_fixed = use_factory_fixed;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_source = SRC_NONE;
          if (method == METHOD_DHCP || method == METHOD_FALLBACK) begin
            next_state = ST_DHCP;
          end else if (method == METHOD_BOOTP) begin
            next_state = ST_BOOTP;
          end else begin
            // Fixed only: custom settings when set, else factory defaults.
            next_source = SRC_FIXED;
            next_use_factory_fixed = !fixed_custom_set;
            next_state = ST_DONE;
          end
        end
      end
      ST_DHCP: begin
        if (dhcp_ok) begin
          next_source = SRC_DHCP;
          next_state = ST_DONE;
        end else if (dhcp_fail) begin
          if (method == METHOD_FALLBACK) begin
            next_state = ST_BOOTP;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_BOOTP: begin
        if (bootp_ok) begin
          next_source = SRC_BOOTP;
          next_state = ST_DONE;
        end else if (bootp_fail) begin
          if (method == METHOD_FALLBACK) begin
            next_source = SRC_FIXED;
            next_use_factory_fixed = !fixed_custom_set;
            next_state = ST_DONE;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_DONE: begin
        // A new start returns to idle and clears the source; the next start begins again.
        if (start) begin
          next_state = ST_IDLE;
          next_source = SRC_NONE;
        end
      end
    endcase
    next_dhcp_run = (next_state == ST_DHCP);
    next_bootp_run = (next_state == ST_BOOTP);
  end

  // State and outputs are all registered.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      source <= SRC_NONE;
      use_factory_fixed <= 1'b0;
      dhcp_run <= 1'b0;
      bootp_run <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      source <= next_source;
      use_factory_fixed <= next_use_factory_fixed;
      dhcp_run <= next_dhcp_run;
      bootp_run <= next_bootp_run;
    end
  end

endmodule

// file: core/bus_controller_net_status_regs.sv
// Network configuration and status register bank of the bus controller.
`timescale 1ns/1ns
//
// Contract
// - Subnet mask low half at 0x0049, reset zero.
// - Gateway high half at 0x004A, reset zero.
// - Gateway low half at 0x004B, reset zero.
// - Method selector 0x004C: fixed, DHCP, BOOTP, fallback.
// - Fallback: DHCP, then BOOTP, then fixed address.
// - Fixed mode uses custom settings, else factory.
// - Status 0x0100 flags active high; bit0 reset.
// - Bits 2,4,5,6,7 report internal/bus/limit/conflict/termination errors.
// - Bits 8..11 report position/supply/unconfigured/incompatible errors.
// - Unused status bits 1,3,12..15 read zero.
// - 0x0101 holds code of last requested operation.
// - 0x0102 counts relay nodes present on chain.
// - 0x0103 counts nodes whose address matches position.
// - 0x0104 counts nodes whose address mismatches position.
// - 0x0105 counts unaddressed nodes; client then auto-addresses.
// - Addresses split high octets first across two words.
// - Writing 3 to 0x0001 arms auto-address at power-up.
module bus_controller_net_status_regs
  import net_status_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire reg_req_t req,
  output reg_resp_t resp,
  input wire ctrl_errors_t ctrl_errors,
  input wire logic op_valid,
  input wire logic [15:0] op_code,
  input wire logic [MAX_NODES-1:0] node_present,
  input wire logic [MAX_NODES-1:0] node_addressed,
  input wire logic [MAX_NODES-1:0] node_addr_match,
  input wire logic assign_start,
  input wire logic fixed_custom_set,
  input wire logic dhcp_ok,
  input wire logic dhcp_fail,
  input wire logic bootp_ok,
  input wire logic bootp_fail,
  output logic [31:0] gateway_addr,
  output logic [15:0] subnet_mask_low_out,
  output logic autoaddr_armed,
  output logic dhcp_run,
  output logic bootp_run,
  output addr_source_t addr_source,
  output logic use_factory_fixed
);

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers and their next values.

  logic [15:0] subnet_mask_low; // Low half of the subnet mask.
  logic [15:0] gateway_high; // Upper two octets of the gateway.
  logic [15:0] gateway_low; // Lower two octets of the gateway.
  logic [15:0] address_assign_method; // Address assignment selector.
  logic [15:0] autoaddr_cmd; // Auto-addressing command word.
  logic [15:0] next_subnet_mask_low;
  logic [15:0] next_gateway_high;
  logic [15:0] next_gateway_low;
  logic [15:0] next_address_assign_method;
  logic [15:0] next_autoaddr_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Status state and its next values.

  logic reset_flag; // Set from reset until the status word is read.
  logic next_reset_flag;
  logic [15:0] last_operation_code; // Most recent operation requested.
  logic [15:0] next_last_operation_code;
  logic [15:0] controller_error_flags; // Assembled status word.
  logic [15:0] next_controller_error_flags;

  // Response register and its next value.
  reg_resp_t next_resp;

  // Registered output copies of configuration.
  logic [31:0] next_gateway_addr;

  // Node tallies from the counting block.
  logic [CNT_W-1:0] present_count;
  logic [CNT_W-1:0] correct_count;
  logic [CNT_W-1:0] misplaced_count;
  logic [CNT_W-1:0] unaddressed_count;

  // Decoded access strobes.
  logic is_write;
  logic is_read_holding;
  logic is_read_input;
  logic status_read;

  ////////////////////////////////////////////////////////////////////////////
  // Counting and sequencing blocks.

  // Relay node tallies, recomputed every enabled cycle.
  node_tally u_node_tally (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .node_present(node_present),
    .node_addressed(node_addressed),
    .node_addr_match(node_addr_match),
    .present_count(present_count),
    .correct_count(correct_count),
    .misplaced_count(misplaced_count),
    .unaddressed_count(unaddressed_count)
  );

  // Address assignment sequencer steered by the method selector.
  addr_assign_seq u_addr_assign_seq (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .method(address_assign_method),
    .start(assign_start),
    .fixed_custom_set(fixed_custom_set),
    .dhcp_ok(dhcp_ok),
    .dhcp_fail(dhcp_fail),
    .bootp_ok(bootp_ok),
    .bootp_fail(bootp_fail),
    .dhcp_run(dhcp_run),
    .bootp_run(bootp_run),
    .source(addr_source),
    .use_factory_fixed(use_factory_fixed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  // One request is handled per enabled cycle; there is no wait state.
  always_comb begin
    is_write = req.valid && (req.kind == ACC_WRITE_HOLDING);
    is_read_holding = req.valid && (req.kind == ACC_READ_HOLDING);
    is_read_input = req.valid && (req.kind == ACC_READ_INPUT);
    status_read = is_read_input && (req.addr == OFF_CONTROLLER_ERROR_FLAGS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding register writes.

  // Holding registers change only on a write to their own offset and keep
  // their value otherwise.
  always_comb begin
    next_subnet_mask_low = subnet_mask_low;
    next_gateway_high = gateway_high;
    next_gateway_low = gateway_low;
    next_address_assign_method = address_assign_method;
    next_autoaddr_cmd = autoaddr_cmd;
    if (is_write) begin
      unique case (req.addr)
        OFF_SUBNET_MASK_LOW: next_subnet_mask_low = req.wdata;
        OFF_GATEWAY_HIGH: next_gateway_high = req.wdata;
        OFF_GATEWAY_LOW: next_gateway_low = req.wdata;
        OFF_ADDRESS_ASSIGN_METHOD: begin
          // Out-of-range codes are refused; the sequencer would take them as fixed.
          if (req.wdata <= METHOD_FALLBACK) begin
            next_address_assign_method = req.wdata;
          end
        end
        OFF_AUTOADDR: begin
          // Only the command value or idle is stored.
          if (req.wdata == AUTOADDR_CMD || req.wdata == AUTOADDR_IDLE) begin
            next_autoaddr_cmd = req.wdata;
          end
        end
        default: begin
          // Unmapped offsets store nothing.
        end
      endcase
    end
  end

  // Holding register flops, reset to their documented defaults.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      subnet_mask_low <= RST_NET_WORD;
      gateway_high <= RST_NET_WORD;
      gateway_low <= RST_NET_WORD;
      address_assign_method <= RST_METHOD;
      autoaddr_cmd <= AUTOADDR_IDLE;
    end else if (ce) begin
      subnet_mask_low <= next_subnet_mask_low;
      gateway_high <= next_gateway_high;
      gateway_low <= next_gateway_low;
      address_assign_method <= next_address_assign_method;
      autoaddr_cmd <= next_autoaddr_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and last operation.

  // The reset flag stays set after reset until a client reads the status
  // word, so a controller restart is never missed by a polling client.
  always_comb begin
    next_reset_flag = reset_flag && !status_read;
    next_controller_error_flags = '0;
    next_controller_error_flags[BIT_RESET] = next_reset_flag;
    next_controller_error_flags[BIT_INTERNAL] = ctrl_errors.internal_err;
    next_controller_error_flags[BIT_BUS] = ctrl_errors.bus_err;
    next_controller_error_flags[BIT_LIMIT] = ctrl_errors.limit_err;
    next_controller_error_flags[BIT_CONFLICT] = ctrl_errors.conflict_err;
    next_controller_error_flags[BIT_TERMINATION] = ctrl_errors.termination_err;
    next_controller_error_flags[BIT_POSITION] = ctrl_errors.position_err;
    next_controller_error_flags[BIT_SUPPLY] = ctrl_errors.supply_err;
    next_controller_error_flags[BIT_UNCONFIGURED] = ctrl_errors.unconfigured_err;
    next_controller_error_flags[BIT_INCOMPATIBLE] = ctrl_errors.incompatible_err;
    next_last_operation_code = last_operation_code;
    // Only known operation codes are recorded; a stray code is dropped.
    if (op_valid) begin
      unique case (op_code)
        OP_ROLL_CALL, OP_AUTOADDR, OP_CHECK_START, OP_CHECK_STOP, OP_BLOCKED: begin
          next_last_operation_code = op_code;
        end
        default: begin
          next_last_operation_code = last_operation_code;
        end
      endcase
    end
  end

  // Status flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_flag <= 1'b1;
      controller_error_flags <= '0;
      last_operation_code <= RST_OPCODE;
    end else if (ce) begin
      reset_flag <= next_reset_flag;
      controller_error_flags <= next_controller_error_flags;
      last_operation_code <= next_last_operation_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and exceptions.

  // Reads return the value before any write of the same cycle. The status
  // word is read from its registered copy, with bit 0 taken from the reset
  // flag flop, so the flag is seen in the same read that clears it.
  always_comb begin
    next_resp.valid = req.valid;
    next_resp.rdata = '0;
    next_resp.exception = EXC_NONE;
    if (is_read_holding) begin
      unique case (req.addr)
        OFF_AUTOADDR: next_resp.rdata = autoaddr_cmd;
        OFF_SUBNET_MASK_LOW: next_resp.rdata = subnet_mask_low;
        OFF_GATEWAY_HIGH: next_resp.rdata = gateway_high;
        OFF_GATEWAY_LOW: next_resp.rdata = gateway_low;
        OFF_ADDRESS_ASSIGN_METHOD: next_resp.rdata = address_assign_method;
        default: next_resp.exception = EXC_ADDRESS;
      endcase
    end else if (is_read_input) begin
      unique case (req.addr)
        OFF_CONTROLLER_ERROR_FLAGS: begin
          next_resp.rdata = controller_error_flags;
          next_resp.rdata[BIT_RESET] = reset_flag;
        end
        OFF_LAST_OPERATION_CODE: next_resp.rdata = last_operation_code;
        OFF_NODES_PRESENT_COUNT: next_resp.rdata = 16'(present_count);
        OFF_NODES_CORRECT_COUNT: next_resp.rdata = 16'(correct_count);
        OFF_NODES_MISPLACED_COUNT: next_resp.rdata = 16'(misplaced_count);
        OFF_NODES_UNADDRESSED_COUNT: next_resp.rdata = 16'(unaddressed_count);
        default: next_resp.exception = EXC_ADDRESS;
      endcase
    end else if (is_write) begin
      // Input registers have no holding offset, so writes to them land here.
      unique case (req.addr)
        OFF_SUBNET_MASK_LOW, OFF_GATEWAY_HIGH, OFF_GATEWAY_LOW: begin
          next_resp.rdata = req.wdata;
        end
        OFF_ADDRESS_ASSIGN_METHOD: begin
          if (req.wdata <= METHOD_FALLBACK) begin
            next_resp.rdata = req.wdata;
          end else begin
            next_resp.exception = EXC_VALUE;
          end
        end
        OFF_AUTOADDR: begin
          if (req.wdata == AUTOADDR_CMD || req.wdata == AUTOADDR_IDLE) begin
            next_resp.rdata = req.wdata;
          end else begin
            next_resp.exception = EXC_VALUE;
          end
        end
        default: next_resp.exception = EXC_ADDRESS;
      endcase
    end else if (req.valid) begin
      next_resp.exception = EXC_FUNCTION;
    end
  end

  // Network word pairing: the high word carries the two leading octets.
  always_comb begin
    next_gateway_addr = {next_gateway_high, next_gateway_low};
  end

  // Response and configuration output flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resp <= '0;
      gateway_addr <= '0;
      subnet_mask_low_out <= RST_NET_WORD;
      autoaddr_armed <= 1'b0;
    end else if (ce) begin
      resp <= next_resp;
      gateway_addr <= next_gateway_addr;
      subnet_mask_low_out <= next_subnet_mask_low;
      autoaddr_armed <= (next_autoaddr_cmd == AUTOADDR_CMD);
    end
  end

endmodule

// file: dv/net_status_props.sv
// Checker on the register bank answers and network outputs.
`timescale 1ns/1ns
module net_status_props
  import net_status_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire reg_req_t req,
  input wire reg_resp_t resp,
  input wire logic [31:0] gateway_addr,
  input wire logic [15:0] subnet_mask_low_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Request owning the present answer; frozen with ce like the answer.
  reg_req_t last;
  logic wr;
  logic rs;
  always_ff @(posedge clk or negedge resetn) last <= !resetn ? '0 : (ce ? req : last);
  assign wr = resp.valid && last.valid && last.kind == ACC_WRITE_HOLDING;
  assign rs = resp.valid && last.valid && last.kind == ACC_READ_INPUT;
  AST_ANSWER: assert property (ce && req.valid ##1 ce |-> resp.valid)
    else $error("no answer");
  AST_QUIET: assert property (ce && !req.valid ##1 ce |-> !resp.valid)
    else $error("stray answer");
  AST_UNUSED: assert property (rs && last.addr == OFF_CONTROLLER_ERROR_FLAGS
    |-> (resp.rdata & 16'hf00a) == 16'h0000) else $error("unused bit set");
  AST_READ_ONLY: assert property (wr && last.addr >= OFF_CONTROLLER_ERROR_FLAGS
    |-> resp.exception == EXC_ADDRESS) else $error("input written");
  AST_METHOD: assert property (wr && last.addr == OFF_ADDRESS_ASSIGN_METHOD
    && last.wdata > 16'h0003 |-> resp.exception == EXC_VALUE) else $error("bad method");
  AST_GW_HIGH: assert property (wr && last.addr == OFF_GATEWAY_HIGH
    |-> gateway_addr[31:16] == last.wdata) else $error("gateway high");
  AST_GW_LOW: assert property (wr && last.addr == OFF_GATEWAY_LOW
    |-> gateway_addr[15:0] == last.wdata) else $error("gateway low");
  AST_MASK: assert property (wr && last.addr == OFF_SUBNET_MASK_LOW
    |-> subnet_mask_low_out == last.wdata) else $error("mask");
  cover property (wr && resp.exception == EXC_VALUE);
  cover property (rs && last.addr == OFF_CONTROLLER_ERROR_FLAGS);
  cover property (wr && last.addr == OFF_GATEWAY_LOW);
endmodule

bind bus_controller_net_status_regs net_status_props u_props (.*);

// file: dv/modbus_client_model.sv
// Behavioural network client issuing one register access at a time.
`timescale 1ns/1ns
module modbus_client_model
  import net_status_pkg::*;
(
  input wire logic clk,
  input wire reg_resp_t resp,
  output reg_req_t req
);
  initial req = '0;
  // Released address and data are inverted so a stale address never looks current.
  task automatic xfer(input access_kind_t k, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] rd, output logic [7:0] ex, output logic ok);
    @(posedge clk);
    req <= '{1'b1, k, a, d};
    @(posedge clk);
    req <= '{1'b0, ACC_NONE, ~a, ~d};
    #1;
    for (int n = 0; n < 4 && resp.valid !== 1'b1; n++) @(posedge clk) #1;
    ok = resp.valid === 1'b1;
    rd = resp.rdata;
    ex = resp.exception;
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench of the network status register bank.
`timescale 1ns/1ns
module testbench
  import net_status_pkg::*;
;
  logic clk = 0, resetn = 0, ce = 1, fixed_custom_set = 0, autoaddr_armed, dhcp_run, bootp_run;
  logic op_valid = 0, assign_start = 0, dhcp_fail = 0, bootp_fail = 0, use_factory_fixed, ok;
  logic [15:0] op_code = '0, subnet_mask_low_out, r;
  logic [MAX_NODES-1:0] node_present = '0, node_addressed = '0, node_addr_match = '0;
  logic [31:0] gateway_addr;
  logic [7:0] x;
  ctrl_errors_t ctrl_errors = '1;
  reg_req_t req;
  reg_resp_t resp;
  addr_source_t addr_source;
  int fail_count = 0, num_checks = 0;
  logic [15:0] ops [5] = '{OP_ROLL_CALL, OP_AUTOADDR, OP_CHECK_START, OP_CHECK_STOP, OP_BLOCKED};
  logic [15:0] cnt [4] = '{16'h0008, 16'h0004, 16'h0002, 16'h0002};
  always #20 clk = ~clk;
  modbus_client_model client (.clk(clk), .resp(resp), .req(req));
  bus_controller_net_status_regs dut (.*, .dhcp_ok(1'b0), .bootp_ok(1'b0));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task test_done;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A missing answer ends the run at once.
  task acc(input access_kind_t k, input logic [15:0] a, input logic [15:0] d);
    client.xfer(k, a, d, r, x, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask
  task rd(input access_kind_t k, input logic [15:0] a, input logic [15:0] e);
    acc(k, a, 16'h0000);
    chk("read", {EXC_NONE, e}, {x, r});
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] e);
    acc(ACC_WRITE_HOLDING, a, d);
    chk("write", e, x);
  endtask
  task pulse(input logic [3:0] m, input logic [15:0] c);
    @(posedge clk);
    {op_valid, assign_start, dhcp_fail, bootp_fail} <= m;
    op_code <= c;
    @(posedge clk);
    {op_valid, assign_start, dhcp_fail, bootp_fail} <= '0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1;
    rd(ACC_READ_INPUT, OFF_CONTROLLER_ERROR_FLAGS, 16'h0ff5);
    @(posedge clk) ctrl_errors <= '0;
    rd(ACC_READ_INPUT, OFF_CONTROLLER_ERROR_FLAGS, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rd(ACC_READ_HOLDING, OFF_SUBNET_MASK_LOW + 16'(i), 16'h0000);
    end
    wr(OFF_SUBNET_MASK_LOW, 16'hff00, EXC_NONE);
    chk("mask", 16'hff00, subnet_mask_low_out);
    wr(OFF_GATEWAY_HIGH, 16'hc0a8, EXC_NONE);
    wr(OFF_GATEWAY_LOW, 16'h0101, EXC_NONE);
    chk("gateway", 32'hc0a8_0101, gateway_addr);
    rd(ACC_READ_HOLDING, OFF_GATEWAY_HIGH, 16'hc0a8);
    // With the clock enable low nothing is taken, so no answer comes.
    @(posedge clk) ce <= 0;
    client.xfer(ACC_WRITE_HOLDING, OFF_GATEWAY_LOW, 16'h5555, r, x, ok);
    chk("frozen", 1'b0, ok);
    @(posedge clk) ce <= 1;
    rd(ACC_READ_HOLDING, OFF_GATEWAY_LOW, 16'h0101);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_ADDRESS_ASSIGN_METHOD, 16'(m), EXC_NONE);
      rd(ACC_READ_HOLDING, OFF_ADDRESS_ASSIGN_METHOD, 16'(m));
    end
    wr(OFF_ADDRESS_ASSIGN_METHOD, 16'h0004, EXC_VALUE);
    rd(ACC_READ_HOLDING, OFF_ADDRESS_ASSIGN_METHOD, METHOD_FALLBACK);
    wr(OFF_NODES_PRESENT_COUNT, 16'h0001, EXC_ADDRESS);
    foreach (ops[i]) begin
      pulse(4'h8, ops[i]);
      rd(ACC_READ_INPUT, OFF_LAST_OPERATION_CODE, ops[i]);
    end
    @(posedge clk) {node_present, node_addressed, node_addr_match} <= {32'hff, 32'h3f, 32'hf};
    for (int i = 0; i < 4; i++) begin
      rd(ACC_READ_INPUT, OFF_NODES_PRESENT_COUNT + 16'(i), cnt[i]);
    end
    if (r !== 16'h0000) wr(OFF_AUTOADDR, AUTOADDR_CMD, EXC_NONE);
    chk("armed", 1'b1, autoaddr_armed);
    pulse(4'h4, 16'h0000);
    chk("dhcp", 1'b1, dhcp_run);
    pulse(4'h2, 16'h0000);
    chk("bootp", 1'b1, bootp_run);
    pulse(4'h1, 16'h0000);
    chk("source", SRC_FIXED, addr_source);
    wr(OFF_ADDRESS_ASSIGN_METHOD, METHOD_FIXED, EXC_NONE);
    pulse(4'h4, 16'h0000);
    pulse(4'h4, 16'h0000);
    chk("factory", {SRC_FIXED, 1'b1}, {addr_source, use_factory_fixed});
    // Custom fixed settings present: the factory defaults must not be used.
    @(posedge clk) fixed_custom_set <= 1;
    pulse(4'h4, 16'h0000);
    pulse(4'h4, 16'h0000);
    chk("custom", {SRC_FIXED, 1'b0}, {addr_source, use_factory_fixed});
    test_done();
  end
endmodule
